// ==== lfp_core.v ====
// Purpose: fault protection decision logic for a six string led driver
// Assumes: comparator flags and pins are async levels, sys_clk 100 MHz
// Notes: enable low clears protection state and shuts the driver down
//
// Function
// - supply low shuts whole driver, overrides all
// - overcurrent blocks boost switch this cycle only
// - overvoltage shuts the boost converter down
// - overvoltage removes all open channels at once
// - channels stay on while overvoltage holds boost
// - boost restarts: lower overvoltage released, all-high low
// - short/long select picks short or long string
// - lowest/highest index pick the single victim
// - all-high means every active channel above feedback
// - all-high blocks string protection, holds boost off
// - thermal stage one disconnects at most one string
// - re-arm after cooling, disconnected strings stay off
// - thermal stage two shuts boost down at once
// - stage two clear restarts boost, strings stay off
// - enable held low keeps driver shut down
// - enable low pulse clears all protection state
// - fault output is open drain, active low
// - short/long select: zero short, one long
// - thermal re-arm waits 800 ms after cooling
// - fault on short, open, overcurrent, over-temperature
// - each new overvoltage trigger drops further open channels
`include "lfp_consts.vh"
`default_nettype none
module lfp_core #(
  parameter NCH = `LFP_NCH,
  parameter REARM_W = `LFP_REARM_W,
  parameter [31:0] REARM_CYCLES = `LFP_REARM_MS * `LFP_CLK_KHZ
) (
  input wire sys_clk,
  input wire resetn,
  input wire enable_pin,
  input wire supply_low_flag,
  input wire switch_overcurrent_flag,
  input wire overvoltage_flag,
  input wire overvoltage_low_flag,
  input wire short_long_sel,
  input wire all_channels_high_flag,
  input wire thermal_stage_one,
  input wire thermal_stage_two,
  input wire short_string_guard,
  input wire boost_cycle_start,
  input wire [NCH-1:0] open_channel_flags,
  input wire [`LFP_IDX_W-1:0] lowest_channel_index,
  input wire [`LFP_IDX_W-1:0] highest_channel_index,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`LFP_ADR_W-1:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  output reg driver_on_q,
  output reg boost_enable_q,
  output reg boost_switch_off_q,
  output reg [NCH-1:0] chan_sink_en_q,
  output reg [NCH-1:0] chan_feedback_q,
  output reg fault_out_n_o_q,
  output reg fault_out_n_oe_n_q
);

////////////////////////////////////////////////////////////////////////////
// helpers

// one-hot of a channel index, zero when out of range
function [NCH-1:0] lfp_onehot;
  input [`LFP_IDX_W-1:0] idx;
  integer i;
  begin
    lfp_onehot = {NCH{1'b0}};
    for (i = 0; i < NCH; i = i + 1) begin
      if (idx == i[`LFP_IDX_W-1:0]) begin
        lfp_onehot[i] = 1'b1;
      end
    end
  end
endfunction

localparam [REARM_W-1:0] REARM_LAST =
  REARM_CYCLES[REARM_W-1:0] - {{(REARM_W-1){1'b0}}, 1'b1};

////////////////////////////////////////////////////////////////////////////
// input synchronisation

wire [`LFP_SY_W-1:0] sy_raw;
wire [`LFP_SY_W-1:0] sy;

assign sy_raw = {highest_channel_index, lowest_channel_index,
                 open_channel_flags, boost_cycle_start, enable_pin,
                 short_string_guard, thermal_stage_two, thermal_stage_one,
                 all_channels_high_flag, short_long_sel,
                 overvoltage_low_flag, overvoltage_flag,
                 switch_overcurrent_flag, supply_low_flag};

lfp_sync #(
  .W(`LFP_SY_W)
) u_sync (
  .sys_clk(sys_clk),
  .resetn(resetn),
  .async_i(sy_raw),
  .sync_o(sy)
);

wire s_uv = sy[`LFP_SY_UV];
wire s_ocp = sy[`LFP_SY_OCP];
wire s_ovp = sy[`LFP_SY_OVP];
wire s_ovp_lo = sy[`LFP_SY_OVP_LO];
wire s_sl = sy[`LFP_SY_SL];
wire s_ach = sy[`LFP_SY_ACH];
wire s_thermal_stage_one = sy[`LFP_SY_THERMAL_STAGE_ONE];
wire s_thermal_stage_two = sy[`LFP_SY_THERMAL_STAGE_TWO];
wire s_slp = sy[`LFP_SY_SLP];
wire s_en = sy[`LFP_SY_EN];
wire s_cyc = sy[`LFP_SY_CYC];
wire [NCH-1:0] s_open = sy[`LFP_SY_OPEN_LSB +: NCH];
wire [`LFP_IDX_W-1:0] s_chl = sy[`LFP_SY_CHL_LSB +: `LFP_IDX_W];
wire [`LFP_IDX_W-1:0] s_chh = sy[`LFP_SY_CHH_LSB +: `LFP_IDX_W];

////////////////////////////////////////////////////////////////////////////
// register bus

wire soft_clr;
reg [31:0] status_w;

lfp_wb u_wb (
  .sys_clk(sys_clk),
  .resetn(resetn),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i),
  .wb_sel_i(wb_sel_i),
  .status_i(status_w),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .soft_clr_o(soft_clr)
);

////////////////////////////////////////////////////////////////////////////
// state

reg [NCH-1:0] active_q, active_d;
reg ovp_hold_q, ovp_hold_d;
reg armed_q, armed_d;
reg [REARM_W-1:0] rearm_cnt_q, rearm_cnt_d;
reg fault_q, fault_d;
reg sw_block_q, sw_block_d;
reg ovp_prev_q;
reg cyc_prev_q;

////////////////////////////////////////////////////////////////////////////
// decision logic

wire clr_all = ~s_en | soft_clr;
wire drv_on = s_en & ~s_uv;
wire ovp_rise = s_ovp & ~ovp_prev_q;
wire cyc_rise = s_cyc & ~cyc_prev_q;

wire ovp_ok = ovp_rise & ~s_uv & ~s_ocp & ~s_thermal_stage_two;
wire [NCH-1:0] open_hit = s_open & active_q;

wire [NCH-1:0] victim = active_q &
  ((s_sl == `LFP_SL_LONG) ? lfp_onehot(s_chl) : lfp_onehot(s_chh));

wire str_trig = (s_thermal_stage_one | s_slp) & armed_q & drv_on & ~s_thermal_stage_two &
                ~s_ach & ~ovp_hold_q & ~s_ovp;

wire fault_set = s_slp | (ovp_ok & (|open_hit)) | s_ocp |
                 s_thermal_stage_one | s_thermal_stage_two;

always @* begin
  active_d = active_q;
  ovp_hold_d = ovp_hold_q;
  armed_d = armed_q;
  rearm_cnt_d = rearm_cnt_q;
  sw_block_d = sw_block_q;
  fault_d = fault_q;

  if (cyc_rise) begin
    sw_block_d = 1'b0;
  end
  if (s_ocp & ~s_uv & ~s_thermal_stage_two) begin
    sw_block_d = 1'b1;
  end

  if (~s_ovp & ~s_ovp_lo & ~s_ach) begin
    ovp_hold_d = 1'b0;
  end
  if (ovp_ok) begin
    ovp_hold_d = 1'b1;
  end

  if (ovp_ok) begin
    active_d = active_d & ~open_hit;
  end

  if (str_trig) begin
    active_d = active_d & ~victim;
    armed_d = 1'b0;
    rearm_cnt_d = {REARM_W{1'b0}};
  end else if (~armed_q) begin
    if (s_thermal_stage_one | s_slp | s_ach) begin
      rearm_cnt_d = {REARM_W{1'b0}};
    end else if (rearm_cnt_q == REARM_LAST) begin
      armed_d = 1'b1;
      rearm_cnt_d = {REARM_W{1'b0}};
    end else begin
      rearm_cnt_d = rearm_cnt_q + {{(REARM_W-1){1'b0}}, 1'b1};
    end
  end

  if (clr_all) begin
    active_d = {NCH{1'b1}};
    ovp_hold_d = 1'b0;
    armed_d = 1'b1;
    rearm_cnt_d = {REARM_W{1'b0}};
    sw_block_d = 1'b0;
  end

  if (clr_all) begin
    fault_d = 1'b0;
  end
  if (fault_set) begin
    fault_d = 1'b1;
  end
end

always @(posedge sys_clk or negedge resetn) begin
  if (!resetn) begin
    active_q <= {NCH{1'b1}};
    ovp_hold_q <= 1'b0;
    armed_q <= 1'b1;
    rearm_cnt_q <= {REARM_W{1'b0}};
    fault_q <= 1'b0;
    sw_block_q <= 1'b0;
    ovp_prev_q <= 1'b0;
    cyc_prev_q <= 1'b0;
  end else begin
    active_q <= active_d;
    ovp_hold_q <= ovp_hold_d;
    armed_q <= armed_d;
    rearm_cnt_q <= rearm_cnt_d;
    fault_q <= fault_d;
    sw_block_q <= sw_block_d;
    ovp_prev_q <= s_ovp;
    cyc_prev_q <= s_cyc;
  end
end

////////////////////////////////////////////////////////////////////////////
// outputs

wire boost_d = drv_on & ~s_thermal_stage_two & ~ovp_hold_d & ~s_ach;

always @(posedge sys_clk or negedge resetn) begin
  if (!resetn) begin
    driver_on_q <= 1'b0;
    boost_enable_q <= 1'b0;
    boost_switch_off_q <= 1'b1;
    chan_sink_en_q <= {NCH{1'b0}};
    chan_feedback_q <= {NCH{1'b0}};
    fault_out_n_o_q <= 1'b0;
    fault_out_n_oe_n_q <= 1'b1;
  end else begin
    driver_on_q <= drv_on;
    boost_enable_q <= boost_d;
    boost_switch_off_q <= ~boost_d | sw_block_d;
    chan_sink_en_q <= active_d & {NCH{drv_on}};
    chan_feedback_q <= active_d & {NCH{drv_on}};
    fault_out_n_o_q <= 1'b0;
    fault_out_n_oe_n_q <= ~fault_d;
  end
end

////////////////////////////////////////////////////////////////////////////
// status word

always @* begin
  status_w = 32'h0000_0000;
  status_w[`LFP_ST_ACTIVE_LSB +: NCH] = active_q;
  status_w[`LFP_ST_FAULT] = fault_q;
  status_w[`LFP_ST_OVP_HOLD] = ovp_hold_q;
  status_w[`LFP_ST_ARMED] = armed_q;
  status_w[`LFP_ST_BOOST_EN] = boost_enable_q;
  status_w[`LFP_ST_SW_BLOCK] = sw_block_q;
  status_w[`LFP_ST_DRIVER_ON] = driver_on_q;
end

endmodule // lfp_core
`default_nettype wire

// ==== lfp_consts.vh ====
// Purpose: shared constants of the led string fault protection block
// Assumes: included by lfp_core and lfp_wb, not by lfp_sync
// Notes: definitions only
`ifndef LFP_CONSTS_VH
`define LFP_CONSTS_VH

// channel count and index width
`define LFP_NCH 6
`define LFP_IDX_W 3

// short/long select encoding
`define LFP_SL_LONG 1'b1

// re-arm delay after thermal stage one clears
`define LFP_REARM_MS 800
`define LFP_CLK_KHZ 100000
`define LFP_REARM_W 27

// wishbone register map, byte addresses
`define LFP_ADR_W 8
`define LFP_ADR_CTRL 8'h00
`define LFP_ADR_STATUS 8'h04
`define LFP_CTRL_CLR_BIT 0

// status word field positions
`define LFP_ST_ACTIVE_LSB 0
`define LFP_ST_FAULT 6
`define LFP_ST_OVP_HOLD 7
`define LFP_ST_ARMED 8
`define LFP_ST_BOOST_EN 9
`define LFP_ST_SW_BLOCK 10
`define LFP_ST_DRIVER_ON 11

// synchronised input vector layout
`define LFP_SY_W 23
`define LFP_SY_UV 0
`define LFP_SY_OCP 1
`define LFP_SY_OVP 2
`define LFP_SY_OVP_LO 3
`define LFP_SY_SL 4
`define LFP_SY_ACH 5
`define LFP_SY_THERMAL_STAGE_ONE 6
`define LFP_SY_THERMAL_STAGE_TWO 7
`define LFP_SY_SLP 8
`define LFP_SY_EN 9
`define LFP_SY_CYC 10
`define LFP_SY_OPEN_LSB 11
`define LFP_SY_CHL_LSB 17
`define LFP_SY_CHH_LSB 20

`endif

// ==== lfp_sync.v ====
// Purpose: two flip-flop synchroniser for a vector of async levels
// Assumes: each bit is an independent level from outside sys_clk
// Notes: stage one is read only by stage two
`default_nettype none
module lfp_sync #(
  parameter W = 1
) (
  input wire sys_clk,
  input wire resetn,
  input wire [W-1:0] async_i,
  output reg [W-1:0] sync_o
);

reg [W-1:0] meta_q;

always @(posedge sys_clk or negedge resetn) begin
  if (!resetn) begin
    meta_q <= {W{1'b0}};
    sync_o <= {W{1'b0}};
  end else begin
    meta_q <= async_i;
    sync_o <= meta_q;
  end
end

endmodule // lfp_sync
`default_nettype wire

// ==== lfp_wb.v ====
// Purpose: classic wishbone slave for control and status words
// Assumes: 32-bit data, byte addresses, one wait state per access
// Notes: unmapped reads return zero, unmapped writes are dropped
`include "lfp_consts.vh"
`default_nettype none
module lfp_wb (
  input wire sys_clk,
  input wire resetn,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`LFP_ADR_W-1:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] status_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg soft_clr_o
);

wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
reg [31:0] rd_d;
reg clr_d;

always @* begin
  rd_d = 32'h0000_0000;
  clr_d = 1'b0;
  if (wb_adr_i == `LFP_ADR_STATUS) begin
    rd_d = status_i;
  end else if (wb_adr_i == `LFP_ADR_CTRL) begin
    rd_d = 32'h0000_0000;
    clr_d = wb_we_i & wb_sel_i[0] & wb_dat_i[`LFP_CTRL_CLR_BIT];
  end
end

always @(posedge sys_clk or negedge resetn) begin
  if (!resetn) begin
    wb_ack_o <= 1'b0;
    wb_dat_o <= 32'h0000_0000;
    soft_clr_o <= 1'b0;
  end else begin
    wb_ack_o <= req;
    soft_clr_o <= req & clr_d;
    if (req & ~wb_we_i) begin
      wb_dat_o <= rd_d;
    end
  end
end

endmodule // lfp_wb
`default_nettype wire

// ==== lfp_checker.sv ====
// Purpose: assertion checker for lfp_core
// Assumes: bound to lfp_core, flags are async levels
// Notes: input to output takes three edges
`default_nettype none
module lfp_checker #(
  parameter NCH = 6
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic enable_pin,
  input wire logic supply_low_flag,
  input wire logic switch_overcurrent_flag,
  input wire logic overvoltage_flag,
  input wire logic all_channels_high_flag,
  input wire logic thermal_stage_one,
  input wire logic thermal_stage_two,
  input wire logic short_string_guard,
  input wire logic driver_on_q,
  input wire logic boost_enable_q,
  input wire logic boost_switch_off_q,
  input wire logic [NCH-1:0] chan_sink_en_q,
  input wire logic [NCH-1:0] chan_feedback_q,
  input wire logic fault_out_n_o_q,
  input wire logic fault_out_n_oe_n_q
);
  logic quiet;
  assign quiet = !(switch_overcurrent_flag || overvoltage_flag ||
    thermal_stage_one || thermal_stage_two || short_string_guard ||
    supply_low_flag);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////
  AST_UV: assert property (
    supply_low_flag [*4] |-> !driver_on_q && boost_switch_off_q)
    else $error("supply low left driver on");
  AST_EN_LOW: assert property (
    !enable_pin [*4] |-> !driver_on_q)
    else $error("enable low left driver on");
  AST_THERMAL_STAGE_TWO: assert property (
    thermal_stage_two [*4] |-> !boost_enable_q)
    else $error("stage two left boost on");
  AST_ACH: assert property (
    all_channels_high_flag [*4] |-> !boost_enable_q)
    else $error("all high left boost on");
  AST_OCP: assert property (
    switch_overcurrent_flag [*4] |-> boost_switch_off_q)
    else $error("overcurrent left switch on");
  AST_OCP_FLT: assert property (
    switch_overcurrent_flag [*4] |-> !fault_out_n_oe_n_q)
    else $error("overcurrent without fault");
  AST_FB: assert property (
    chan_feedback_q == chan_sink_en_q)
    else $error("feedback differs from sinks");
  AST_OD: assert property (
    !fault_out_n_oe_n_q |-> !fault_out_n_o_q)
    else $error("fault pin driven high");
  AST_CLR_CH: assert property (
    (!enable_pin && quiet) [*4] ##1 (enable_pin && quiet) [*4]
    |-> &chan_sink_en_q)
    else $error("enable pulse kept a channel off");
  AST_CLR_FLT: assert property (
    (!enable_pin && quiet) [*4] ##1 (enable_pin && quiet) [*4]
    |-> fault_out_n_oe_n_q)
    else $error("enable pulse kept fault");
endmodule // lfp_checker
bind lfp_core lfp_checker #(.NCH(NCH)) lfp_checker_inst (.*);
`default_nettype wire

// ==== lfp_partner.sv ====
// Purpose: comparator and boost model facing lfp_core
// Assumes: open strings pull their channel to ground
// Notes: boost with an open active string trips overvoltage
`default_nettype none
module lfp_partner #(
  parameter LO = 1,
  parameter HI = 4
) (
  input wire logic sys_clk,
  input wire logic vdd_low,
  input wire logic ocp_req,
  input wire logic sl_req,
  input wire logic [1:0] temp_lvl,
  input wire logic [5:0] open_str,
  input wire logic [5:0] chan_sink_en_q,
  input wire logic boost_enable_q,
  output logic supply_low_flag,
  output logic switch_overcurrent_flag,
  output logic overvoltage_flag,
  output logic overvoltage_low_flag,
  output logic short_long_sel,
  output logic all_channels_high_flag,
  output logic thermal_stage_one,
  output logic thermal_stage_two,
  output logic short_string_guard,
  output logic boost_cycle_start,
  output logic [5:0] open_channel_flags,
  output logic [2:0] lowest_channel_index,
  output logic [2:0] highest_channel_index
);
  logic [3:0] div_q = 4'h0;
  assign short_string_guard = 1'b0;
  assign lowest_channel_index = 3'(LO);
  assign highest_channel_index = 3'(HI);
  always_ff @(posedge sys_clk) begin
    div_q <= div_q + 4'h1;
    boost_cycle_start <= div_q[3];
    supply_low_flag <= vdd_low;
    switch_overcurrent_flag <= ocp_req;
    short_long_sel <= sl_req;
    thermal_stage_one <= temp_lvl != 2'h0;
    thermal_stage_two <= temp_lvl == 2'h2;
    open_channel_flags <= open_str & chan_sink_en_q;
    overvoltage_flag <= boost_enable_q && |(open_str & chan_sink_en_q);
    // lower threshold releases one cycle later
    overvoltage_low_flag <= overvoltage_flag;
    all_channels_high_flag <= sl_req && !chan_sink_en_q[LO] &&
      |chan_sink_en_q;
  end
endmodule // lfp_partner
`default_nettype wire

// ==== test_led_string_fault_protection.sv ====
// Purpose: directed test of lfp_core
// Assumes: partner model drives all flags
// Notes: short re-arm count for simulation
`include "lfp_consts.vh"
`default_nettype none
module test_led_string_fault_protection;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, resetn = 1'b0, enable_pin = 1'b1;
  logic vdd_low = 1'b0, ocp_req = 1'b0, sl_req = 1'b0;
  logic [1:0] temp_lvl = 2'h0;
  logic [5:0] open_str = 6'h00;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [3:0] wb_sel_i = 4'hf;
  logic supply_low_flag, switch_overcurrent_flag, overvoltage_flag;
  logic overvoltage_low_flag, short_long_sel, all_channels_high_flag;
  logic thermal_stage_one, thermal_stage_two, short_string_guard;
  logic boost_cycle_start, wb_ack_o, driver_on_q, boost_enable_q;
  logic [5:0] open_channel_flags, chan_sink_en_q, chan_feedback_q;
  logic [2:0] lowest_channel_index, highest_channel_index;
  logic boost_switch_off_q, fault_out_n_o_q, fault_out_n_oe_n_q, pin;
  int bad_count = 0, n_compared = 0;
  assign pin = fault_out_n_oe_n_q ? 1'b1 : fault_out_n_o_q;
  always #5 sys_clk = ~sys_clk;
  lfp_partner lfp_partner_inst (.*);
  lfp_core #(.REARM_CYCLES(32'd20)) lfp_core_inst (.*);
  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int i;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (i >= 20) begin
      chk("ack", 1'b0, 1'b1);
      stop_test();
    end
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk("read", q, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(16);
    resetn <= 1'b1;
    cyc(8);
    rd(`LFP_ADR_STATUS, 32'h0000_0b3f);
    chk("pin", pin, 1'b1);
    rd(8'h08, 32'h0);
    wr(`LFP_ADR_STATUS, 32'hffff_ffff);
    rd(`LFP_ADR_STATUS, 32'h0000_0b3f);
    sl_req <= 1'b1;
    temp_lvl <= 2'h1;
    cyc(10);
    chk("sinks", chan_sink_en_q, 6'h3d);
    chk("pin", pin, 1'b0);
    chk("boost", boost_enable_q, 1'b0);
    temp_lvl <= 2'h0;
    cyc(60);
    rd(`LFP_ADR_STATUS, 32'h0000_087d);
    wr(`LFP_ADR_CTRL, 32'h1);
    sl_req <= 1'b0;
    cyc(8);
    chk("sinks", chan_sink_en_q, 6'h3f);
    chk("pin", pin, 1'b1);
    temp_lvl <= 2'h1;
    cyc(8);
    chk("sinks", chan_sink_en_q, 6'h2f);
    temp_lvl <= 2'h0;
    cyc(10);
    rd(`LFP_ADR_STATUS, 32'h0000_0a6f);
    cyc(40);
    rd(`LFP_ADR_STATUS, 32'h0000_0b6f);
    temp_lvl <= 2'h2;
    cyc(6);
    chk("boost", boost_enable_q, 1'b0);
    temp_lvl <= 2'h0;
    cyc(6);
    chk("boost", boost_enable_q, 1'b1);
    chk("sinks", chan_sink_en_q, 6'h2f);
    open_str <= 6'h05;
    cyc(16);
    chk("sinks", chan_sink_en_q, 6'h2a);
    chk("feedback", chan_feedback_q, 6'h2a);
    chk("boost", boost_enable_q, 1'b1);
    open_str <= 6'h07;
    cyc(16);
    chk("sinks", chan_sink_en_q, 6'h28);
    open_str <= 6'h00;
    ocp_req <= 1'b1;
    cyc(5);
    chk("switch", boost_switch_off_q, 1'b1);
    chk("sinks", chan_sink_en_q, 6'h28);
    ocp_req <= 1'b0;
    cyc(24);
    chk("switch", boost_switch_off_q, 1'b0);
    vdd_low <= 1'b1;
    cyc(5);
    chk("driver", driver_on_q, 1'b0);
    chk("boost", boost_enable_q, 1'b0);
    vdd_low <= 1'b0;
    cyc(5);
    chk("pin", pin, 1'b0);
    enable_pin <= 1'b0;
    cyc(6);
    chk("driver", driver_on_q, 1'b0);
    enable_pin <= 1'b1;
    cyc(6);
    chk("sinks", chan_sink_en_q, 6'h3f);
    chk("pin", pin, 1'b1);
    stop_test();
  end
endmodule // test_led_string_fault_protection
`default_nettype wire
